// *** core/tpl_pkg.sv ***
// Shared constants of the touch probe position latch and its controller
package tpl_pkg;

  // ------------------------------------------------------------
  // Object indices of the device side
  // ------------------------------------------------------------
  localparam logic [15:0] OBJ_POSITION_RANGE_LIMIT = 16'h607B;
  localparam logic [15:0] OBJ_PROBE_FUNCTION_CONTROL = 16'h60B8;
  localparam logic [15:0] OBJ_PROBE_STATUS_FLAGS = 16'h60B9;
  localparam logic [15:0] OBJ_PROBE_CAPTURED_POSITION = 16'h60BA;
  localparam logic [15:0] OBJ_POSITIONING_OPTION_CODE = 16'h60F2;

  // ------------------------------------------------------------
  // Field layout and codes
  // ------------------------------------------------------------
  localparam int NUM_LATCH = 5;
  localparam int CW_FAULT_ACK_BIT = 7;
  localparam int PF_SEL_LSB = 8;
  localparam int PS_ACK_LSB = 8;
  localparam int POC_MODE_LSB = 6;
  localparam logic [1:0] PROBE_IMPL_STD = 2'h1;
  localparam logic [1:0] PROBE_IMPL_VENDOR = 2'h2;
  localparam logic [7:0] INPUT_FN_MEASURE = 8'h0F;
  localparam logic [15:0] FAULT_CLEAR_PARAM_NUM = 16'h0099;
  localparam logic [15:0] FAULT_CLEAR_VALUE = 16'h0001;
  localparam logic [63:0] EMCY_ACK_DATA = 64'h0000000000000000;
  localparam logic [1:0] TABLE_LINEAR = 2'h0;
  localparam logic [1:0] TABLE_LEFT = 2'h1;
  localparam logic [1:0] TABLE_RIGHT = 2'h2;
  localparam logic [1:0] TABLE_SHORTEST = 2'h3;

  // ------------------------------------------------------------
  // Controller register map (AHB-Lite byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CONTROL_WORD = 8'h00;
  localparam logic [7:0] REG_PROBE_FUNCTION = 8'h04;
  localparam logic [7:0] REG_POSITION_OPTION = 8'h08;
  localparam logic [7:0] REG_RANGE_LIMIT = 8'h0C;
  localparam logic [7:0] REG_PROBE_SETUP = 8'h10;
  localparam logic [7:0] REG_FAULT_CLEAR = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_POSITION = 8'h1C;
  localparam logic [7:0] REG_EMCY_LOW = 8'h20;
  localparam logic [7:0] REG_EMCY_HIGH = 8'h24;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h28;
  localparam logic [7:0] REG_IRQ_MASK = 8'h2C;
  localparam int IRQ_EMCY = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_CONTROL_WORD = 16'h0000;
  localparam logic [15:0] RST_PROBE_FUNCTION = 16'h0000;
  localparam logic [15:0] RST_POSITION_OPTION = 16'h0000;
  localparam logic [31:0] RST_RANGE_LIMIT = 32'h00000000;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  typedef enum {FAULT_IDLE, FAULT_ACTIVE, FAULT_CLEARED} tpl_fault_t;

endpackage

// *** core/tpl_link_if.sv ***
// Process data link between the fieldbus controller and the probe unit
`timescale 1ns/100ps
interface tpl_link_if;
  logic [15:0] control_word;
  logic [15:0] probe_function;
  logic [15:0] position_option;
  logic [31:0] range_limit;
  logic [1:0] probe_impl;
  logic [7:0] input_fn_one;
  logic [7:0] input_fn_two;
  logic fault_clear_wr;
  logic [15:0] fault_clear_value;
  logic [15:0] probe_status;
  logic [31:0] probe_position;
  logic emcy_valid;
  logic [63:0] emcy_data;
  logic fault_active;

  modport dev (
    input control_word, probe_function, position_option, range_limit,
    input probe_impl, input_fn_one, input_fn_two,
    input fault_clear_wr, fault_clear_value,
    output probe_status, probe_position, emcy_valid, emcy_data,
    output fault_active
  );
  modport ctl (
    output control_word, probe_function, position_option, range_limit,
    output probe_impl, input_fn_one, input_fn_two,
    output fault_clear_wr, fault_clear_value,
    input probe_status, probe_position, emcy_valid, emcy_data,
    input fault_active
  );
endinterface

// *** core/tpl_probe_unit.sv ***
// Device end: position capture latches, fault acknowledgement, table mode
//
// What this block does
// - Rising control bit 7 acknowledges error
// - Cleared error sends all-zero emergency message
// - Persisting error resends emergency, re-enters fault
// - Writing 1 to parameter 153 clears
// - Capture on two inputs and index
// - Master selects implementation value 2 only; the controller refuses only value 1 and passes 0 and 3 on
// - Master sets input function code 15
// - Function bits 0-4 arm five latches
// - Function bits 8-12 select read latch
// - Master re-arms by clearing then setting
// - Armed event sets matching valid bit
// - Status bits 8-11 echo read code
// - Position output follows set acknowledge code
// - Option bits 6-7 give table direction
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
module tpl_probe_unit
  import tpl_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  tpl_link_if.dev link,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic index_pulse,
  input wire logic [POS_W-1:0] drive_position,
  input wire logic error_cause,
  input wire logic [15:0] error_code,
  output logic [1:0] table_mode,
  output logic [31:0] range_limit_out
);

  // ------------------------------------------------------------
  // Edge detection on the event inputs
  // ------------------------------------------------------------
  logic in_one_q;
  logic in_two_q;
  logic index_q;
  logic [NUM_LATCH-1:0] event_hit;
  logic fn_one_ok;
  logic fn_two_ok;
  logic impl_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_one_q <= 1'b0;
      in_two_q <= 1'b0;
      index_q <= 1'b0;
    end else begin
      in_one_q <= capture_input_one;
      in_two_q <= capture_input_two;
      index_q <= index_pulse;
    end
  end

  // Vendor variant only; the standard one is refused outright
  assign impl_ok = (link.probe_impl == PROBE_IMPL_VENDOR);
  assign fn_one_ok = (link.input_fn_one == INPUT_FN_MEASURE);
  assign fn_two_ok = (link.input_fn_two == INPUT_FN_MEASURE);

  always_comb begin
    event_hit = '0;
    if (impl_ok) begin
      event_hit[0] = fn_one_ok && capture_input_one && !in_one_q;
      event_hit[1] = fn_one_ok && !capture_input_one && in_one_q;
      event_hit[2] = fn_two_ok && capture_input_two && !in_two_q;
      event_hit[3] = fn_two_ok && !capture_input_two && in_two_q;
      event_hit[4] = index_pulse && !index_q;
    end
  end

  // ------------------------------------------------------------
  // Latches
  // ------------------------------------------------------------
  logic [NUM_LATCH-1:0] arm_q;
  logic [NUM_LATCH-1:0] armed;
  logic [NUM_LATCH-1:0] valid;
  logic [POS_W-1:0] stored [NUM_LATCH];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_q <= '0;
    end else begin
      arm_q <= link.probe_function[NUM_LATCH-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
      logic arm_rise;
      logic arm_on;
      assign arm_on = link.probe_function[gi];
      // Arming is edge controlled, a held bit never re-arms
      assign arm_rise = arm_on && !arm_q[gi];

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          armed[gi] <= 1'b0;
        end else if (!arm_on) begin
          armed[gi] <= 1'b0;
        end else if (arm_rise) begin
          armed[gi] <= 1'b1;
        end else if (event_hit[gi]) begin
          armed[gi] <= 1'b0;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          valid[gi] <= 1'b0;
        end else if (!arm_on || arm_rise) begin
          valid[gi] <= 1'b0;
        end else if (armed[gi] && event_hit[gi]) begin
          valid[gi] <= 1'b1;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stored[gi] <= '0;
        end else if (armed[gi] && event_hit[gi] && !arm_rise) begin
          stored[gi] <= drive_position;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read selection, acknowledge code and position value
  // ------------------------------------------------------------
  logic [4:0] read_sel;
  logic sel_legal;
  logic sel_valid;
  logic [2:0] sel_idx;
  logic [3:0] ack_code;

  assign read_sel = link.probe_function[PF_SEL_LSB +: 5];
  assign sel_legal = (read_sel >= 5'h01) && (read_sel <= 5'h05);
  assign sel_idx = 3'(read_sel - 5'h01);
  assign sel_valid = sel_legal && valid[sel_idx];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_code <= 4'h0;
    end else if (sel_valid) begin
      ack_code <= read_sel[3:0];
    end else begin
      ack_code <= 4'h0;
    end
  end

  // Position lags the code by one edge and changes only while the code is nonzero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.probe_position <= 32'h00000000;
    end else if (ack_code != 4'h0) begin
      link.probe_position <= 32'(stored[3'(ack_code - 4'h1)]);
    end
  end

  assign link.probe_status = {4'h0, ack_code, 3'h0, valid};

  // ------------------------------------------------------------
  // Fault acknowledgement and emergency messages
  // ------------------------------------------------------------
  logic cw_ack_q;
  logic ack_req;
  tpl_fault_t fault_state;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cw_ack_q <= 1'b0;
    end else begin
      cw_ack_q <= link.control_word[CW_FAULT_ACK_BIT];
    end
  end

  // Either mechanism is enough; both together still give one clear
  assign ack_req = (link.control_word[CW_FAULT_ACK_BIT] && !cw_ack_q)
    || (link.fault_clear_wr
        && link.fault_clear_value == FAULT_CLEAR_VALUE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_state <= FAULT_IDLE;
    end else begin
      case (fault_state)
        FAULT_IDLE: begin
          if (error_cause) begin
            fault_state <= FAULT_ACTIVE;
          end
        end
        FAULT_ACTIVE: begin
          if (ack_req) begin
            fault_state <= FAULT_CLEARED;
          end
        end
        FAULT_CLEARED: begin
          if (error_cause) begin
            fault_state <= FAULT_ACTIVE;
          end else begin
            fault_state <= FAULT_IDLE;
          end
        end
        default: fault_state <= FAULT_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.emcy_valid <= 1'b0;
      link.emcy_data <= EMCY_ACK_DATA;
    end else begin
      link.emcy_valid <= 1'b0;
      case (fault_state)
        FAULT_IDLE: begin
          if (error_cause) begin
            link.emcy_valid <= 1'b1;
            link.emcy_data <= {48'h000000000000, error_code};
          end
        end
        FAULT_ACTIVE: begin
          if (ack_req) begin
            link.emcy_valid <= 1'b1;
            link.emcy_data <= EMCY_ACK_DATA;
          end
        end
        FAULT_CLEARED: begin
          if (error_cause) begin
            link.emcy_valid <= 1'b1;
            link.emcy_data <= {48'h000000000000, error_code};
          end
        end
        default: link.emcy_valid <= 1'b0;
      endcase
    end
  end

  assign link.fault_active = (fault_state == FAULT_ACTIVE);

  // ------------------------------------------------------------
  // Indexing table option and range limit
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_mode <= TABLE_LINEAR;
      range_limit_out <= RST_RANGE_LIMIT;
    end else begin
      table_mode <= link.position_option[POC_MODE_LSB +: 2];
      range_limit_out <= link.range_limit;
    end
  end

endmodule

// *** core/tpl_bus_ctrl.sv ***
// Controller end: AHB-Lite register file driving the probe link
`timescale 1ns/100ps
module tpl_bus_ctrl
  import tpl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  tpl_link_if.ctl link
);

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_take;
  logic wr_take;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= haddr[7:0];
    end
  end

  // ------------------------------------------------------------
  // Link registers
  // ------------------------------------------------------------
  logic [2:0] irq_mask;
  logic [2:0] irq_stat;
  logic [63:0] emcy_seen;
  logic [4:0] valid_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.control_word <= RST_CONTROL_WORD;
      link.probe_function <= RST_PROBE_FUNCTION;
      link.position_option <= RST_POSITION_OPTION;
      link.range_limit <= RST_RANGE_LIMIT;
      link.probe_impl <= PROBE_IMPL_VENDOR;
      link.input_fn_one <= INPUT_FN_MEASURE;
      link.input_fn_two <= INPUT_FN_MEASURE;
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_pend) begin
      case (wr_addr)
        // Software makes the bit 7 edge by writing 0 then 1
        REG_CONTROL_WORD: link.control_word <= hwdata[15:0];
        // Re-arm is software clearing then setting a bit
        REG_PROBE_FUNCTION: link.probe_function <= hwdata[15:0];
        REG_POSITION_OPTION: link.position_option <= hwdata[15:0];
        REG_RANGE_LIMIT: link.range_limit <= hwdata;
        REG_PROBE_SETUP: begin
          // The unsupported selector value is never passed on
          if (hwdata[1:0] != PROBE_IMPL_STD) begin
            link.probe_impl <= hwdata[1:0];
          end
          link.input_fn_one <= hwdata[15:8];
          link.input_fn_two <= hwdata[23:16];
        end
        REG_IRQ_MASK: irq_mask <= hwdata[2:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Fault clear parameter: a one-cycle write strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.fault_clear_wr <= 1'b0;
      link.fault_clear_value <= 16'h0000;
    end else begin
      link.fault_clear_wr <= wr_pend && (wr_addr == REG_FAULT_CLEAR);
      link.fault_clear_value <= hwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emcy_seen <= 64'h0000000000000000;
      valid_q <= 5'h00;
    end else begin
      valid_q <= link.probe_status[4:0];
      if (link.emcy_valid) begin
        emcy_seen <= link.emcy_data;
      end
    end
  end

  assign irq_set[IRQ_EMCY] = link.emcy_valid;
  assign irq_set[IRQ_CAPTURE] = |(link.probe_status[4:0] & ~valid_q);
  assign irq_set[IRQ_FAULT] = link.fault_active;
  assign irq_clr = (wr_pend && wr_addr == REG_IRQ_STATUS) ?
    hwdata[2:0] : 3'h0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      case (haddr[7:0])
        REG_CONTROL_WORD: hrdata <= {16'h0000, link.control_word};
        REG_PROBE_FUNCTION: hrdata <= {16'h0000, link.probe_function};
        REG_POSITION_OPTION: hrdata <= {16'h0000, link.position_option};
        REG_RANGE_LIMIT: hrdata <= link.range_limit;
        REG_PROBE_SETUP: hrdata <= {8'h00, link.input_fn_two,
          link.input_fn_one, 6'h00, link.probe_impl};
        REG_STATUS: hrdata <= {15'h0000, link.fault_active,
          link.probe_status};
        REG_POSITION: hrdata <= link.probe_position;
        REG_EMCY_LOW: hrdata <= emcy_seen[31:0];
        REG_EMCY_HIGH: hrdata <= emcy_seen[63:32];
        REG_IRQ_STATUS: hrdata <= {29'h00000000, irq_stat};
        REG_IRQ_MASK: hrdata <= {29'h00000000, irq_mask};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** sim/tpl_link_asserts.sv ***
// Checker of the probe link between controller end and device end
`timescale 1ns/100ps
module tpl_link_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] control_word,
  input wire logic [15:0] probe_function,
  input wire logic fault_clear_wr,
  input wire logic [15:0] fault_clear_value,
  input wire logic [15:0] probe_status,
  input wire logic [31:0] probe_position,
  input wire logic emcy_valid,
  input wire logic [63:0] emcy_data,
  input wire logic fault_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic clr_ok;
  assign clr_ok = fault_clear_wr && fault_clear_value == 16'h0001;
  // ----
  // Fault acknowledgement
  // ----
  property p_bit7_ack;
    fault_active && $rose(control_word[7]) |=> emcy_valid && emcy_data == 64'h0;
  endproperty
  a_bit7_ack: assert property (p_bit7_ack) else $error("no clear message");
  // Zero message only as answer to an edge or a clear write
  property p_zero_cause;
    emcy_valid && emcy_data == 64'h0 |-> $past(fault_active) &&
      ($past(control_word[7]) && !$past(control_word[7], 2) || $past(clr_ok));
  endproperty
  a_zero_cause: assert property (p_zero_cause) else $error("stray clear");
  property p_clear_param;
    fault_active && clr_ok |=> emcy_valid && !fault_active;
  endproperty
  a_clear_param: assert property (p_clear_param) else $error("param clear");
  property p_bad_value;
    fault_active && fault_clear_wr && fault_clear_value != 16'h0001 &&
      !$rose(control_word[7]) |=> fault_active;
  endproperty
  a_bad_value: assert property (p_bad_value) else $error("bad value cleared");
  property p_fell_zero;
    $fell(fault_active) |-> emcy_valid && emcy_data == 64'h0;
  endproperty
  a_fell_zero: assert property (p_fell_zero) else $error("silent clear");
  property p_reenter;
    $rose(fault_active) |-> emcy_valid;
  endproperty
  a_reenter: assert property (p_reenter) else $error("silent fault");
  property p_emcy_hold;
    !emcy_valid |-> $stable(emcy_data);
  endproperty
  a_emcy_hold: assert property (p_emcy_hold) else $error("message moved");
  // ----
  // Capture status
  // ----
  property p_valid_armed;
    ((probe_status[4:0] & ~$past(probe_status[4:0])) &
      ~$past(probe_function[4:0])) == 5'h00;
  endproperty
  a_valid_armed: assert property (p_valid_armed) else $error("unarmed valid");
  property p_fields;
    probe_status[15:12] == 4'h0 && probe_status[7:5] == 3'h0 &&
      probe_status[11:8] <= 4'h5;
  endproperty
  a_fields: assert property (p_fields) else $error("status field");
  property p_ack_sel;
    probe_status[11:8] != 4'h0 |->
      {1'b0, probe_status[11:8]} == $past(probe_function[12:8]);
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack code");
  property p_pos_ack;
    $changed(probe_position) |-> $past(probe_status[11:8]) != 4'h0;
  endproperty
  a_pos_ack: assert property (p_pos_ack) else $error("early position");
  c_zero_emcy: cover property (emcy_valid && emcy_data == 64'h0);
  c_capture: cover property ($rose(probe_status[4]));
  c_reenter: cover property ($fell(fault_active) ##1 $rose(fault_active));
endmodule

// *** sim/tb.sv ***
// Bench joining controller and device end, driven over AHB-Lite
`timescale 1ns/100ps
module tb;
  import tpl_pkg::*;
  localparam int LIMIT = 6000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic capture_input_one = 1'b0;
  logic capture_input_two = 1'b0;
  logic index_pulse = 1'b0;
  logic [31:0] drive_position = 32'h0;
  logic error_cause = 1'b0;
  logic [15:0] error_code = 16'hA5C3;
  logic [1:0] table_mode;
  logic [31:0] range_limit_out;
  logic [31:0] rd_val;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int i;
  tpl_link_if u_tpl_link_if ();
  tpl_bus_ctrl u_tpl_bus_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .link(u_tpl_link_if.ctl));
  tpl_probe_unit u_tpl_probe_unit (
    .hclk(hclk), .hresetn(hresetn), .link(u_tpl_link_if.dev),
    .capture_input_one(capture_input_one),
    .capture_input_two(capture_input_two), .index_pulse(index_pulse),
    .drive_position(drive_position), .error_cause(error_cause),
    .error_code(error_code), .table_mode(table_mode),
    .range_limit_out(range_limit_out));
  tpl_link_asserts u_tpl_link_asserts (
    .hclk(hclk), .hresetn(hresetn),
    .control_word(u_tpl_link_if.control_word),
    .probe_function(u_tpl_link_if.probe_function),
    .fault_clear_wr(u_tpl_link_if.fault_clear_wr),
    .fault_clear_value(u_tpl_link_if.fault_clear_value),
    .probe_status(u_tpl_link_if.probe_status),
    .probe_position(u_tpl_link_if.probe_position),
    .emcy_valid(u_tpl_link_if.emcy_valid),
    .emcy_data(u_tpl_link_if.emcy_data),
    .fault_active(u_tpl_link_if.fault_active));
  always #50 hclk = ~hclk;
  // ----
  // Bus tasks and reporting
  // ----
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Entered just after a rising edge, returns just after one
  task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Latches 0,1 watch input one, 2,3 input two, 4 the index
  task automatic set_src(input int k, input logic v);
    case (k)
      0, 1: capture_input_one <= v;
      2, 3: capture_input_two <= v;
      default: index_pulse <= v;
    endcase
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(REG_CONTROL_WORD, 32'h0);
    rd_chk(REG_PROBE_SETUP, 32'h000F0F02);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_IRQ_MASK, 32'h0);
    rd_chk(8'h40, 32'h0);
    chk(hresp, 1'b0);
    for (int m = 0; m < 4; m++) begin
      ahb_xfer(1'b1, REG_POSITION_OPTION, {16'h0, 8'hA1, m[1:0], 6'h3F});
      tick(2);
      chk(table_mode, m[1:0]);
    end
    ahb_xfer(1'b1, REG_RANGE_LIMIT, 32'h80000001);
    tick(2);
    chk(range_limit_out, 32'h80000001);
    // Unsupported selector value is refused
    ahb_xfer(1'b1, REG_PROBE_SETUP, 32'h000F0F01);
    rd_chk(REG_PROBE_SETUP, 32'h000F0F02);
    // Pass 5 re-arms latch 0 after it was cleared
    for (int k = 0; k < 6; k++) begin
      i = k % 5;
      set_src(i, i[0]);
      drive_position <= 32'h10000000 + 32'(k);
      ahb_xfer(1'b1, REG_PROBE_FUNCTION, 32'((i + 1) << 8 | 1 << i));
      tick(2);
      set_src(i, ~i[0]);
      tick(3);
      set_src(i, i[0]);
      drive_position <= 32'hFFFF0000;
      tick(3);
      set_src(i, ~i[0]);
      tick(3);
      rd_chk(REG_STATUS, 32'((i + 1) << 8 | 1 << i));
      rd_chk(REG_POSITION, 32'h10000000 + 32'(k));
      // Selection code 6 is out of range: valid stays, no acknowledge
      ahb_xfer(1'b1, REG_PROBE_FUNCTION, 32'(6 << 8 | 1 << i));
      tick(2);
      rd_chk(REG_STATUS, 32'(1 << i));
      ahb_xfer(1'b1, REG_PROBE_FUNCTION, 32'h0);
      set_src(i, 1'b0);
      tick(2);
    end
    // Capture stays off without input function 15 or selector 2
    for (int s = 0; s < 2; s++) begin
      ahb_xfer(1'b1, REG_PROBE_SETUP,
               s ? 32'h000F0F03 : 32'h000F0002);
      ahb_xfer(1'b1, REG_PROBE_FUNCTION, 32'h00000101);
      tick(2);
      set_src(0, 1'b1);
      tick(3);
      rd_chk(REG_STATUS, 32'h0);
      ahb_xfer(1'b1, REG_PROBE_FUNCTION, 32'h0);
      set_src(0, 1'b0);
      tick(2);
    end
    ahb_xfer(1'b1, REG_PROBE_SETUP, 32'h000F0F02);
    rd_chk(REG_PROBE_SETUP, 32'h000F0F02);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_IRQ_STATUS, 32'h2);
    ahb_xfer(1'b1, REG_IRQ_STATUS, 32'h7);
    rd_chk(REG_IRQ_STATUS, 32'h0);
    error_cause <= 1'b1;
    tick(3);
    rd_chk(REG_STATUS, 32'h00010000);
    rd_chk(REG_EMCY_LOW, 32'h0000A5C3);
    ahb_xfer(1'b1, REG_IRQ_MASK, 32'h1);
    tick(1);
    chk(irq, 1'b1);
    ahb_xfer(1'b1, REG_IRQ_MASK, 32'h0);
    tick(1);
    chk(irq, 1'b0);
    ahb_xfer(1'b1, REG_IRQ_MASK, 32'h1);
    ahb_xfer(1'b1, REG_IRQ_STATUS, 32'h1);
    tick(1);
    chk(irq, 1'b0);
    // Cause still present: cleared, then back in fault
    ahb_xfer(1'b1, REG_CONTROL_WORD, 32'h80);
    tick(4);
    rd_chk(REG_STATUS, 32'h00010000);
    rd_chk(REG_EMCY_LOW, 32'h0000A5C3);
    chk(irq, 1'b1);
    error_cause <= 1'b0;
    tick(3);
    rd_chk(REG_STATUS, 32'h00010000);
    ahb_xfer(1'b1, REG_CONTROL_WORD, 32'h0);
    ahb_xfer(1'b1, REG_CONTROL_WORD, 32'h80);
    tick(3);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_EMCY_LOW, 32'h0);
    rd_chk(REG_EMCY_HIGH, 32'h0);
    error_cause <= 1'b1;
    tick(3);
    error_cause <= 1'b0;
    ahb_xfer(1'b1, REG_FAULT_CLEAR, 32'h2);
    tick(3);
    rd_chk(REG_STATUS, 32'h00010000);
    ahb_xfer(1'b1, REG_FAULT_CLEAR, 32'h1);
    tick(3);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_EMCY_LOW, 32'h0);
    wrap_up();
  end
endmodule
